// *** logic/adc_ctl_consts.svh ***
// constants for the converter control and result block
// assumes inclusion from the package and the design modules only
`ifndef ADC_CTL_CONSTS_SVH
`define ADC_CTL_CONSTS_SVH
`define ADC_REG_CTLA        4'h0
`define ADC_REG_CTLB        4'h1
`define ADC_REG_RES_LO      4'h2
`define ADC_REG_RES_HI      4'h3
`define ADC_REG_STATUS      4'h4
`define ADC_REG_MASK        4'h5
`define ADC_REG_REFCH       4'h7
`define ADC_REFCH_RST       8'h00
`define ADC_CTLA_RST        8'h00
`define ADC_CTLB_RST        8'h00
`define ADC_CTLA_EN_BIT     7
`define ADC_CTLA_START_BIT  6
`define ADC_CTLA_DONE_BIT   4
`define ADC_CTLB_BIN_BIT    7
`define ADC_TEMP_CODE       6'h22
`define ADC_GAIN_BIT        0
`define ADC_SWAP_BIT        5
`define ADC_LONG_CYCLES     25
`define ADC_NORM_CYCLES     13
`define ADC_CODE_MAX        10'h3ff
`define ADC_BIP_MIN         10'h200
`define ADC_BIP_MAX         10'h1ff
`endif

// *** logic/adc_ctl_pkg.sv ***
// types for the converter control and result block
// assumes the constants header sits beside it
`include "adc_ctl_consts.svh"
package adc_ctl_pkg;
  typedef enum logic [1:0]
  {
    REF_SUPPLY   = 2'b00,
    REF_EXTERNAL = 2'b01,
    REF_INTERNAL = 2'b10,
    REF_RESERVED = 2'b11
  } ref_sel_t;
  typedef enum logic [1:0]
  {
    CONV_IDLE = 2'b00,
    CONV_RUN  = 2'b01,
    CONV_DONE = 2'b10
  } conv_state_t;
  typedef enum logic [1:0]
  {
    IN_SINGLE  = 2'b00,
    IN_UNIPOL  = 2'b01,
    IN_BIPOL   = 2'b10
  } in_kind_t;
endpackage

// *** logic/adc_result_format.sv ***
// result formatter: turns a raw signed difference into the ten-bit code
// assumes raw sample from the analog core is stable while valid_i is high
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctl_consts.svh"
module adc_result_format
  import adc_ctl_pkg::*;
#(
  parameter int RAW_W = 12
)
(
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    valid_i,
  input  wire adc_ctl_pkg::in_kind_t   kind_i,
  input  wire logic signed [RAW_W-1:0] raw_i,
  output logic             [9:0]       code_o
);
  import adc_ctl_pkg::*;
  if (RAW_W < 12)
  begin
    $error("raw width too small");
  end
  // raw is the scaled difference at 1024 per reference, signed
  wire logic signed [RAW_W-1:0] half_w = raw_i >>> 1;
  wire logic [9:0] uni_w =
    (raw_i < 0) ? 10'h000 :
    (raw_i > $signed({{(RAW_W-10){1'b0}}, `ADC_CODE_MAX})) ? `ADC_CODE_MAX :
    raw_i[9:0];
  wire logic [9:0] bip_w =
    (half_w > $signed({{(RAW_W-10){1'b0}}, `ADC_BIP_MAX})) ? `ADC_BIP_MAX :
    (half_w < -$signed({{(RAW_W-10){1'b0}}, 10'h200})) ? `ADC_BIP_MIN :
    half_w[9:0];
  wire logic [9:0] code_w = (kind_i == IN_BIPOL) ? bip_w : uni_w;
  logic [9:0] code_q;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      code_q <= 10'h000;
    else if (valid_i)
      code_q <= code_w;
  end
  assign code_o = code_q;
endmodule
`default_nettype wire

// *** logic/adc_result_ref_select.sv ***
// converter control: register bank, deferred reference/channel apply, result bytes
// assumes classic wishbone master, analog core on the same clock with a
// one-cycle adc clock enable; the analog core returns a signed raw sample
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctl_consts.svh"
module adc_result_ref_select
  import adc_ctl_pkg::*;
#(
  parameter int RAW_W = 12
)
(
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic [3:0]              wb_adr_i,
  input  wire logic [31:0]             wb_dat_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic                    wb_we_i,
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  output logic      [31:0]             wb_dat_o,
  output logic                         wb_ack_o,
  output logic                         irq_o,
  input  wire logic                    adc_clk_en_i,
  input  wire logic signed [RAW_W-1:0] raw_sample_i,
  output logic      [1:0]              ref_sel_o,
  output logic      [5:0]              channel_sel_o,
  output logic                         gain_20x_o,
  output logic                         polarity_swap_o,
  output logic                         temp_sensor_en_o,
  output logic                         sample_o,
  output logic                         busy_o
);
  import adc_ctl_pkg::*;
  if (RAW_W < 12)
  begin
    $error("raw width too small");
  end
  function automatic logic is_diff(input logic [5:0] ch);
    is_diff = (ch[5:3] != 3'b000) && !(ch[5:3] == 3'b100 && ch[2:0] < 3'd3);
  endfunction

  // register bank
  logic [7:0]  refch_q;
  logic [7:0]  ctla_q;
  logic [7:0]  ctlb_q;
  logic        status_q;
  logic        mask_q;
  logic [7:0]  act_q;
  logic [9:0]  result_q;
  logic        long_q;
  logic [4:0]  cnt_q;
  logic        ack_q;
  logic [31:0] rdat_q;
  conv_state_t state_q;
  logic        busy_q;
  logic        sample_q;

  wire logic       req_w     = wb_cyc_i && wb_stb_i && !ack_q;
  wire logic       wr_w      = req_w && wb_we_i && wb_sel_i[0];
  wire logic       wr_refch  = wr_w && (wb_adr_i == `ADC_REG_REFCH);
  wire logic       wr_ctla   = wr_w && (wb_adr_i == `ADC_REG_CTLA);
  wire logic       wr_ctlb   = wr_w && (wb_adr_i == `ADC_REG_CTLB);
  wire logic       wr_stat   = wr_w && (wb_adr_i == `ADC_REG_STATUS);
  wire logic       wr_mask   = wr_w && (wb_adr_i == `ADC_REG_MASK);
  wire logic       enabled_w = ctla_q[`ADC_CTLA_EN_BIT];
  wire logic       running_w = (state_q == CONV_RUN);
  wire logic       start_w   = enabled_w && !running_w && ctla_q[`ADC_CTLA_START_BIT];
  wire logic [4:0] len_w     = long_q ? 5'(`ADC_LONG_CYCLES) : 5'(`ADC_NORM_CYCLES);
  wire logic       finish_w  = running_w && adc_clk_en_i && (cnt_q == len_w - 5'd1);
  wire logic       diff_w    = is_diff(act_q[5:0]);
  wire in_kind_t   kind_w    = !diff_w ? IN_SINGLE :
                               (ctlb_q[`ADC_CTLB_BIN_BIT] ? IN_BIPOL : IN_UNIPOL);
  wire logic [9:0] code_w;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      refch_q <= `ADC_REFCH_RST;
      ctlb_q  <= `ADC_CTLB_RST;
      mask_q  <= 1'b0;
    end
    else
    begin
      if (wr_refch)
        refch_q <= wb_dat_i[7:0];
      if (wr_ctlb)
        ctlb_q <= wb_dat_i[7:0];
      if (wr_mask)
        mask_q <= wb_dat_i[`ADC_CTLA_DONE_BIT];
    end
  end

  // settings are copied to the core only between conversions
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      act_q  <= `ADC_REFCH_RST;
      long_q <= 1'b1;
    end
    else
    begin
      if (!running_w)
        act_q <= refch_q;
      // cleared only at the end, so the stretched length covers the whole run
      if (!enabled_w || (!running_w && refch_q[7:6] != act_q[7:6]))
        long_q <= 1'b1;
      else if (finish_w)
        long_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctla_q <= `ADC_CTLA_RST;
      state_q <= CONV_IDLE;
      cnt_q <= 5'd0;
      busy_q <= 1'b0;
      sample_q <= 1'b0;
    end
    else
    begin
      if (wr_ctla)
        ctla_q <= {wb_dat_i[7:6], 6'h00};
      case (state_q)
        CONV_IDLE:
        begin
          cnt_q <= 5'd0;
          if (start_w && !(refch_q != act_q))
          begin
            state_q  <= CONV_RUN;
            busy_q   <= 1'b1;
            sample_q <= 1'b1;
          end
        end
        CONV_RUN:
        begin
          if (adc_clk_en_i)
          begin
            cnt_q    <= cnt_q + 5'd1;
            sample_q <= 1'b0;
          end
          if (finish_w)
          begin
            state_q <= CONV_DONE;
            busy_q  <= 1'b0;
          end
        end
        CONV_DONE:
        begin
          ctla_q[`ADC_CTLA_START_BIT] <= 1'b0;
          state_q <= CONV_IDLE;
        end
        default:
          state_q <= CONV_IDLE;
      endcase
    end
  end

  // done flag: hardware set wins over a write-one clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      status_q <= 1'b0;
    else if (state_q == CONV_DONE)
      status_q <= 1'b1;
    else if (wr_stat && wb_dat_i[`ADC_CTLA_DONE_BIT])
      status_q <= 1'b0;
  end

  adc_result_format #(
    .RAW_W (RAW_W)
  ) u_fmt (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .valid_i (finish_w),
    .kind_i  (kind_w),
    .raw_i   (raw_sample_i),
    .code_o  (code_w)
  );

  // result registers change only with the done flag
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      result_q <= 10'h000;
    else if (state_q == CONV_DONE)
      result_q <= code_w;
  end

  wire logic [7:0] rd_w =
    (wb_adr_i == `ADC_REG_REFCH)  ? refch_q :
    (wb_adr_i == `ADC_REG_CTLA)   ? ctla_q :
    (wb_adr_i == `ADC_REG_CTLB)   ? ctlb_q :
    (wb_adr_i == `ADC_REG_RES_LO) ? result_q[7:0] :
    (wb_adr_i == `ADC_REG_RES_HI) ? {6'h00, result_q[9:8]} :
    (wb_adr_i == `ADC_REG_STATUS) ? {3'h0, status_q, 4'h0} :
    (wb_adr_i == `ADC_REG_MASK)   ? {3'h0, mask_q, 4'h0} : 8'h00;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q  <= req_w;
      rdat_q <= req_w ? {24'h00_0000, rd_w} : 32'h0000_0000;
    end
  end

  // core controls, registered
  logic [1:0] ref_q;
  logic [5:0] ch_q;
  logic       gain_q;
  logic       swap_q;
  logic       temp_q;
  logic       irq_q;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ref_q  <= 2'b00;
      ch_q   <= 6'h00;
      gain_q <= 1'b0;
      swap_q <= 1'b0;
      temp_q <= 1'b0;
      irq_q  <= 1'b0;
    end
    else
    begin
      ref_q  <= act_q[7:6];
      ch_q   <= act_q[5:0];
      gain_q <= diff_w && act_q[`ADC_GAIN_BIT];
      swap_q <= diff_w && act_q[`ADC_SWAP_BIT];
      temp_q <= (act_q[5:0] == `ADC_TEMP_CODE);
      irq_q  <= (status_q || state_q == CONV_DONE) && mask_q;
    end
  end

  assign wb_ack_o         = ack_q;
  assign wb_dat_o         = rdat_q;
  assign irq_o            = irq_q;
  assign ref_sel_o        = ref_q;
  assign channel_sel_o    = ch_q;
  assign gain_20x_o       = gain_q;
  assign polarity_swap_o  = swap_q;
  assign temp_sensor_en_o = temp_q;
  assign sample_o         = sample_q;
  assign busy_o           = busy_q;

  // checks
  AST_HOLD_REF: assert property (@(posedge clk_i) disable iff (rst_i)
    running_w && $stable(state_q) |=> $stable(act_q[7:6]))
    else $error("reference changed mid conversion");
  AST_HOLD_CH: assert property (@(posedge clk_i) disable iff (rst_i)
    running_w && $stable(state_q) |=> $stable(act_q[5:0]))
    else $error("channel changed mid conversion");
  AST_RESULT: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == CONV_DONE |=> status_q && result_q == $past(code_w))
    else $error("result not loaded with done");
  AST_TEMP: assert property (@(posedge clk_i) disable iff (rst_i)
    act_q[5:0] == `ADC_TEMP_CODE |=> temp_q)
    else $error("sensor not enabled");
  AST_GAIN: assert property (@(posedge clk_i) disable iff (rst_i)
    !diff_w |=> !gain_q && !swap_q)
    else $error("gain on single-ended");
  AST_LONG: assert property (@(posedge clk_i) disable iff (rst_i)
    !running_w && refch_q[7:6] != act_q[7:6] |=> long_q)
    else $error("long conversion not armed");
  AST_UNI_CLAMP: assert property (@(posedge clk_i) disable iff (rst_i)
    finish_w && kind_w == IN_UNIPOL && raw_sample_i < 0 |=> code_w == 10'h000)
    else $error("unipolar not clamped");
  AST_SIGN: assert property (@(posedge clk_i) disable iff (rst_i)
    finish_w && kind_w == IN_BIPOL && raw_sample_i < -2 |=> code_w[9])
    else $error("sign bit wrong");
  AST_BIN: assert property (@(posedge clk_i) disable iff (rst_i)
    diff_w && !ctlb_q[`ADC_CTLB_BIN_BIT] |-> kind_w == IN_UNIPOL)
    else $error("bipolar without select");
  COV_LONG: cover property (@(posedge clk_i) long_q && finish_w);
  COV_BIP: cover property (@(posedge clk_i) finish_w && kind_w == IN_BIPOL);
  COV_TEMP: cover property (@(posedge clk_i) temp_q && state_q == CONV_DONE);
endmodule
`default_nettype wire

// *** testbench/adc_core_model.sv ***
// analog core stand-in: adc clock enable and held raw sample
// assumes it shares the control block clock and reset
`timescale 1ns/1ps
`default_nettype none
module adc_core_model
(
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               slow_i,
  input  wire logic               sample_i,
  input  wire logic signed [11:0] level_i,
  output logic                    tick_o,
  output logic signed [11:0]      raw_o
);
  logic [2:0] div_q;
  // slow mode halves the adc clock rate
  always_ff @(posedge clk_i)
  begin
    if (rst_i) div_q <= 3'h0;
    else div_q <= div_q + 3'h1;
  end
  assign tick_o = slow_i ? (div_q == 3'h7) : (div_q[1:0] == 2'h3);
  // held from the sampling instant, not tracking the input
  always_ff @(posedge clk_i)
  begin
    if (rst_i) raw_o <= 12'h000;
    else if (sample_i) raw_o <= level_i;
  end
endmodule
`default_nettype wire

// *** testbench/tb.sv ***
// self-checking bench for the converter control block
// assumes design files and the analog core model compile first
`timescale 1ns/1ps
`default_nettype none
module tb;
  import adc_ctl_pkg::*;
  logic               clk_i, rst_i, cyc, stb, we, ack, slow, tick, smp, busy, irq;
  logic               gain, swp, temp;
  logic [3:0]         adr;
  logic [31:0]        dat, rdat;
  logic signed [11:0] lvl, raw, v;
  logic [1:0]         refs;
  logic [5:0]         ch;
  logic [8:0]         q[$];
  logic [8:0]         e;
  int                 err_count, compares, seed, cyc_n, cnt, n, t_long, t_norm;
  logic [7:0]         cb[5] = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h80};
  logic [7:0]         rm[5] = '{8'h40, 8'h48, 8'h49, 8'h48, 8'h48};
  logic [11:0]        rw[5] = '{12'h3ff, 12'hffb, 12'h2bc, 12'hda8, 12'h7d0};
  logic [9:0]         cd[5] = '{10'h3ff, 10'h000, 10'h2bc, 10'h2d4, 10'h1ff};
  logic [7:0]         rc[3] = '{8'ha2, 8'h49, 8'h68};
  logic [2:0]         gs[3] = '{3'b001, 3'b100, 3'b010};
  logic [2:0]         gm[3] = '{3'b001, 3'b111, 3'b111};

  adc_result_ref_select adc_result_ref_select_inst (.clk_i(clk_i), .rst_i(rst_i),
    .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'hf), .wb_we_i(we), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq), .adc_clk_en_i(tick),
    .raw_sample_i(raw), .ref_sel_o(refs), .channel_sel_o(ch), .gain_20x_o(gain),
    .polarity_swap_o(swp), .temp_sensor_en_o(temp), .sample_o(smp), .busy_o(busy));
  adc_core_model adc_core_model_inst (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow),
    .sample_i(smp), .level_i(lvl), .tick_o(tick), .raw_o(raw));

  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic check(input string nm, input logic [31:0] s, input logic [31:0] x);
    compares++;
    if (s !== x)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, x, s);
    end
  endtask

  task automatic summarize();
    $display("err_count %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // expectation queued at request time, compared by the monitor at ack
  task automatic bus(input logic [3:0] a, input logic w, input logic [7:0] d,
                     input logic [8:0] x);
    @(posedge clk_i);
    adr <= a; we <= w; dat <= {24'h0, d}; cyc <= 1'b1; stb <= 1'b1;
    q.push_back(x);
    do @(posedge clk_i); while (ack !== 1'b1);
    cyc <= 1'b0; stb <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] x);
    bus(a, 1'b0, 8'h00, {1'b1, x});
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(a, 1'b1, d, 9'h000);
  endtask

  // one conversion; mid rewrites the settings while busy
  task automatic conv(input logic [11:0] lv, input logic mid, input logic mk);
    int k;
    lvl <= lv;
    wr(4'h0, 8'hc0);
    k = 0;
    while (busy !== 1'b1 && k < 50)
    begin
      @(posedge clk_i);
      k++;
    end
    if (mid)
    begin
      wr(4'h7, 8'h41);
      check("held", {24'h0, refs, ch}, 32'h80);
    end
    while (busy === 1'b1)
    begin
      @(posedge clk_i);
      n = cnt;
    end
    repeat (2) @(posedge clk_i);
    check("irq", {31'h0, irq}, {31'h0, mk});
    wr(4'h4, 8'h10);
    repeat (2) @(posedge clk_i);
    check("irq clr", {31'h0, irq}, 32'h0);
  endtask

  always @(posedge clk_i)
  begin
    cyc_n <= cyc_n + 1;
    if (busy !== 1'b1) cnt <= 0;
    else if (tick) cnt <= cnt + 1;
    if (ack === 1'b1)
    begin
      e = q.pop_front();
      if (e[8]) check("rdata", rdat, {24'h0, e[7:0]});
    end
    if (cyc_n == 20000)
    begin
      err_count++;
      summarize();
    end
  end

  initial
  begin
    seed = 94163; err_count = 0; compares = 0; cyc_n = 0; cnt = 0;
    rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 4'h0; dat = 32'h0;
    lvl = 12'h000; slow = 1'b0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(4'h7, 8'h00);
    rd(4'h1, 8'h00);
    wr(4'h6, 8'hff);
    rd(4'h6, 8'h00);
    wr(4'h5, 8'h10);
    wr(4'h7, 8'h80);
    v = 12'($unsigned($random(seed)) % 1024);
    conv(v, 1'b0, 1'b1);
    t_long = n;
    rd(4'h2, v[7:0]);
    rd(4'h3, {6'h0, v[9:8]});
    check("ref", {30'h0, refs}, 32'h2);
    slow <= 1'b1;
    conv(v, 1'b1, 1'b1);
    slow <= 1'b0;
    t_norm = n;
    check("applied", {24'h0, refs, ch}, 32'h41);
    conv(v, 1'b0, 1'b1);
    check("long", 32'(n - t_norm), 32'd12);
    check("long eq", 32'(n), 32'(t_long));
    wr(4'h5, 8'h00);
    conv(v, 1'b0, 1'b0);
    wr(4'h5, 8'h10);
    for (int i = 0; i < 5; i++)
    begin
      wr(4'h1, cb[i]);
      wr(4'h7, rm[i]);
      conv(rw[i], 1'b0, 1'b1);
      rd(4'h2, cd[i][7:0]);
      rd(4'h3, {6'h0, cd[i][9:8]});
    end
    for (int i = 0; i < 3; i++)
    begin
      wr(4'h7, rc[i]);
      repeat (3) @(posedge clk_i);
      check("route", {29'h0, {gain, swp, temp} & gm[i]}, {29'h0, gs[i]});
      check("chan", {26'h0, ch}, {26'h0, rc[i][5:0]});
    end
    summarize();
  end
endmodule
`default_nettype wire
